/* File: bucket_if.sv */
// Carries a programmed mantissa to the bucket mapper and the ms back.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ns
interface bucket_if;
    logic [6:0] mant;
    logic [6:0] ms;
    modport req (output mant, input ms);
    modport map (input mant, output ms);
endinterface

/* File: testbench.sv */
// Self-checking bench for turn-off timing and fault summary.
// Assumes a 10-cycle millisecond so whole sequences stay short.
`timescale 1ns/1ns
module testbench;
    import toff_pkg::*;
    localparam int CMS = 10;
    logic        clk, rst, valid, wr, store, stop, start, en;
    logic        nvwr, fall, ramping, off, ack, nack, a, n;
    logic [7:0]  code, vst, ist, tst, cst, nst, sum;
    logic [15:0] wdata, rdata, nvw, nvr, rd;
    int          fails, comparisons;
    int          mt[22] = '{0, 1, 6, 7, 8, 9, 10, 12, 13, 17, 18, 22, 23,
                            32, 33, 44, 45, 62, 63, 86, 87, 127};
    toff_status #(.CYC_MS(CMS)) toff_status_inst (.CLK_IN(clk),
        .RST_IN(rst), .CMD_VALID_IN(valid), .CMD_WRITE_IN(wr),
        .CMD_CODE_IN(code), .CMD_WDATA_IN(wdata), .CMD_RDATA_OUT(rdata),
        .CMD_ACK_OUT(ack), .CMD_NACK_OUT(nack), .STORE_ALL_IN(store),
        .NV_WR_OUT(nvwr), .NV_WAIT_OUT(nvw), .NV_RAMP_OUT(nvr),
        .STOP_REQ_IN(stop), .START_REQ_IN(start), .FALL_START_OUT(fall),
        .RAMPING_OUT(ramping), .OUTPUT_OFF_OUT(off), .CONV_EN_IN(en),
        .VOUT_STATUS_IN(vst), .IOUT_STATUS_IN(ist), .TEMP_STATUS_IN(tst),
        .CML_STATUS_IN(cst), .INPUT_STATUS_IN(nst), .SUMMARY_OUT(sum));
    toff_host toff_host_inst (.clk_in(clk), .valid_out(valid),
        .write_out(wr), .code_out(code), .wdata_out(wdata),
        .rdata_in(rdata), .ack_in(ack), .nack_in(nack));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic int ms_of(int m, bit ramp);
        int lim[8] = '{9, 12, 17, 22, 32, 44, 62, 86};
        int val[8] = '{7, 10, 14, 19, 27, 37, 52, 72};
        if (m <= 6)
            return (ramp && m == 0) ? 1 : m;
        for (int i = 0; i < 8; i++)
            if (m <= lim[i])
                return val[i];
        return 100;
    endfunction
    function automatic logic [7:0] sum_of();
        return {1'b0, !en, vst[7], ist[7], 1'b0, |tst, |cst,
                |vst[6:2] | (|ist[6:0]) | (|nst)};
    endfunction
    task automatic chk(logic [15:0] got, logic [15:0] exp, string msg);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask
    task automatic run_seq(int m);
        int k;
        toff_host_inst.cmd(1'b1, CMD_TOFF_WAIT, 16'(m), rd, a, n);
        toff_host_inst.cmd(1'b1, CMD_TOFF_RAMP, 16'(m), rd, a, n);
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        @(posedge clk) stop <= 1'b1;
        @(posedge clk) stop <= 1'b0;
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end
        while (fall !== 1'b1 && k < 1100);
        chk(16'(k), 16'(ms_of(m, 0) * CMS + 1), "wait");
        k = 0;
        while (ramping === 1'b1 && k < 1100)
        begin
            k++;
            @(negedge clk);
        end
        chk(16'(k), 16'(ms_of(m, 1) * CMS), "ramp");
        chk({15'h0, off}, 16'h0001, "off");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        end_of_test();
    end
    initial
    begin
        rst = 1'b1;
        {store, stop, start, en} = 4'h0;
        {vst, ist, tst, cst} = 32'h0000_0000;
        nst = 8'h08;
        void'($urandom(35));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({8'h00, sum}, 16'h0041, "reset summary");
        chk({15'h0, off}, 16'h0001, "reset off");
        toff_host_inst.cmd(1'b0, CMD_TOFF_WAIT, 16'h0000, rd, a, n);
        chk(rd, 16'h0000, "wait reset");
        toff_host_inst.cmd(1'b0, CMD_TOFF_RAMP, 16'h0000, rd, a, n);
        chk(rd, 16'h0000, "ramp reset");
        $display("reset test done");
        for (int i = 0; i < 12; i++)
        begin
            logic [15:0] d;
            logic [7:0]  c;
            d = 16'($urandom);
            c = (i % 2) ? CMD_TOFF_RAMP : CMD_TOFF_WAIT;
            toff_host_inst.cmd(1'b1, c, d, rd, a, n);
            chk({15'h0, a}, 16'h0001, "write ack");
            toff_host_inst.cmd(1'b0, c, 16'h0000, rd, a, n);
            chk(rd, {9'h000, d[6:0]}, "readback");
        end
        toff_host_inst.cmd(1'b1, CMD_SUMMARY, 16'h0000, rd, a, n);
        chk({14'h0, a, n}, 16'h0001, "summary write");
        toff_host_inst.cmd(1'b1, 8'h66, 16'h0000, rd, a, n);
        chk({14'h0, a, n}, 16'h0001, "unknown code");
        toff_host_inst.cmd(1'b0, CMD_SUMMARY, 16'h0000, rd, a, n);
        chk(rd, 16'h0041, "summary kept");
        $display("register test done");
        for (int i = 0; i < 30; i++)
        begin
            @(posedge clk);
            en  <= 1'($urandom);
            vst <= (i < 3) ? 8'h00 : 8'($urandom);
            ist <= (i < 3) ? 8'h00 : 8'($urandom);
            tst <= (i % 3) ? 8'h00 : 8'($urandom);
            cst <= (i % 4) ? 8'h00 : 8'($urandom);
            nst <= (i % 2) ? 8'h00 : 8'($urandom);
            @(posedge clk);
            @(negedge clk);
            chk({8'h00, sum}, {8'h00, sum_of()},
                "summary");
        end
        toff_host_inst.cmd(1'b0, CMD_SUMMARY, 16'h0000, rd, a, n);
        chk(rd, {8'h00, sum_of()}, "summary read");
        $display("summary test done");
        foreach (mt[i])
            run_seq(mt[i]);
        run_seq(int'($urandom_range(127)));
        @(posedge clk) stop <= 1'b1;
        @(posedge clk) stop <= 1'b0;
        repeat (3) @(negedge clk);
        chk({14'h0, fall, off}, 16'h0001, "stop in off");
        $display("sequence test done");
        toff_host_inst.cmd(1'b1, CMD_TOFF_RAMP, 16'hFF95, rd, a, n);
        toff_host_inst.cmd(1'b1, CMD_TOFF_WAIT, 16'hFF8A, rd, a, n);
        @(posedge clk) store <= 1'b1;
        @(posedge clk) store <= 1'b0;
        @(negedge clk);
        chk({15'h0, nvwr}, 16'h0001, "store pulse");
        chk(nvr, 16'h0015, "stored ramp");
        chk(nvw, 16'h000A, "stored wait");
        $display("store test done");
        end_of_test();
    end
endmodule

/* File: toff_bucket.sv */
// Maps a turn-off mantissa onto one of sixteen supported times.
// Assumes a purely combinational use by the sequencer.
`timescale 1ns/1ns
module toff_bucket
    import toff_pkg::*;
#(
    parameter bit ZERO_IS_ONE = 1'b0
)
(
    bucket_if.map b
);
    always_comb
    begin
        if (b.mant == 7'h00)
            b.ms = ZERO_IS_ONE ? 7'h01 : 7'h00; // [R04] [R08] [R09]
        else if (b.mant <= 7'h06)
            b.ms = b.mant;              // [R04] [R09]
        else if (b.mant <= 7'h09)
            b.ms = 7'h07;               // [R04]
        else if (b.mant <= 7'h0C)
            b.ms = 7'h0A;               // [R04]
        else if (b.mant <= 7'h11)
            b.ms = 7'h0E;               // [R05]
        else if (b.mant <= 7'h16)
            b.ms = 7'h13;               // [R05]
        else if (b.mant <= 7'h20)
            b.ms = 7'h1B;               // [R05]
        else if (b.mant <= 7'h2C)
            b.ms = 7'h25;               // [R05]
        else if (b.mant <= 7'h3E)
            b.ms = 7'h34;               // [R05]
        else if (b.mant <= 7'h56)
            b.ms = 7'h48;               // [R05]
        else
            b.ms = 7'h64;               // [R03] [R05]
    end
endmodule

/* File: toff_host.sv */
// Host model issuing commands on the turn-off command port.
// Assumes the testbench supplies the clock and owns reset.
`timescale 1ns/1ns
module toff_host
(
    input  wire logic        clk_in,
    output logic             valid_out,
    output logic             write_out,
    output logic      [7:0]  code_out,
    output logic      [15:0] wdata_out,
    input  wire logic [15:0] rdata_in,
    input  wire logic        ack_in,
    input  wire logic        nack_in
);
    initial
    begin
        valid_out = 1'b0;
        write_out = 1'b0;
        code_out  = 8'h00;
        wdata_out = 16'h0000;
    end
    // One command, held through its taking edge
    task automatic cmd(input logic w, input logic [7:0] c,
                       input logic [15:0] d, output logic [15:0] rd,
                       output logic a, output logic n);
        @(posedge clk_in);
        valid_out <= 1'b1;
        write_out <= w;
        code_out  <= c;
        wdata_out <= d;
        @(posedge clk_in);
        valid_out <= 1'b0;
        wdata_out <= ~d;
        @(negedge clk_in);
        rd = rdata_in;
        a  = ack_in;
        n  = nack_in;
    endtask
endmodule

/* File: toff_pkg.sv */
// Constants for the turn-off timing settings and fault summary byte.
// Assumes a single 100 MHz clock and a command port driven by the
// device's own bus front end.
// Contract
// R01 - Exponent fixed at zero, unit 1 ms
// R02 - Upper mantissa bits zero, low seven writable
// R03 - Sixteen wait durations chosen by buckets
// R04 - Wait 0..6 exact, then 7, 10
// R05 - Wait higher buckets 14 through 100 ms
// R06 - Wait counts from stop until fall starts
// R07 - Ramp runs from wait end to zero
// R08 - Ramp zero means active 1 ms ramp
// R09 - Ramp buckets like wait, zero gives 1
// R10 - Ramp setting saved on store-all command
// R11 - Summary read-only, bits 7 and 3 zero
// R12 - Bit 6 set while converter not enabled
// R13 - Bit 5 follows output overvoltage fault
// R14 - Bit 4 follows output overcurrent fault
// R15 - Mirrored bits masked only at source
// R16 - Bit 2 set for temperature fault/warning
// R17 - Bit 1 set for communication/memory/logic fault
// R18 - Bit 0 set for all other faults
// R19 - Bit 0 resets to one via input
// R20 - Writes never clear summary bits
package toff_pkg;
    localparam logic [7:0]  CMD_TOFF_WAIT  = 8'h64;
    localparam logic [7:0]  CMD_TOFF_RAMP  = 8'h65;
    localparam logic [7:0]  CMD_SUMMARY    = 8'h78;
    localparam int          MANT_W         = 7;
    localparam logic [4:0]  EXP_FIXED      = 5'h00;
    localparam logic [6:0]  MANT_RESET     = 7'h00;
    localparam logic [7:0]  SUMMARY_RESET  = 8'h41;
    localparam int          SUM_OFF_BIT    = 6;
    localparam int          SUM_OVF_BIT    = 5;
    localparam int          SUM_OCF_BIT    = 4;
    localparam int          SUM_TEMP_BIT   = 2;
    localparam int          SUM_CML_BIT    = 1;
    localparam int          SUM_OTH_BIT    = 0;
    localparam int          SRC_FAULT_BIT  = 7;
    localparam int          MS_NS          = 1000000;
    localparam int          CLK_NS         = 10;
    localparam int          CYC_PER_MS     = MS_NS / CLK_NS;
    typedef enum logic [1:0]
    {
        ST_RUN  = 2'b00,
        ST_WAIT = 2'b01,
        ST_RAMP = 2'b10,
        ST_OFF  = 2'b11
    } seq_t;
endpackage

/* File: toff_status.sv */
// Turn-off wait/ramp settings, turn-off sequencer and fault summary.
// Assumes lower-level status registers and masks live outside and
// that the command port is fed by the device's bus front end.
`timescale 1ns/1ns
module toff_status
    import toff_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
)
(
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        CMD_VALID_IN,
    input  wire logic        CMD_WRITE_IN,
    input  wire logic [7:0]  CMD_CODE_IN,
    input  wire logic [15:0] CMD_WDATA_IN,
    output logic      [15:0] CMD_RDATA_OUT,
    output logic             CMD_ACK_OUT,
    output logic             CMD_NACK_OUT,
    input  wire logic        STORE_ALL_IN,
    output logic             NV_WR_OUT,
    output logic      [15:0] NV_WAIT_OUT,
    output logic      [15:0] NV_RAMP_OUT,
    input  wire logic        STOP_REQ_IN,
    input  wire logic        START_REQ_IN,
    output logic             FALL_START_OUT,
    output logic             RAMPING_OUT,
    output logic             OUTPUT_OFF_OUT,
    input  wire logic        CONV_EN_IN,
    input  wire logic [7:0]  VOUT_STATUS_IN,
    input  wire logic [7:0]  IOUT_STATUS_IN,
    input  wire logic [7:0]  TEMP_STATUS_IN,
    input  wire logic [7:0]  CML_STATUS_IN,
    input  wire logic [7:0]  INPUT_STATUS_IN,
    output logic      [7:0]  SUMMARY_OUT
);
    typedef struct packed {
        seq_t        state;
        logic [31:0] div;
        logic [6:0]  cnt;
        logic [6:0]  wait_m;
        logic [6:0]  ramp_m;
        logic [7:0]  sum;
        logic [15:0] rdata;
        logic        ack;
        logic        nack;
        logic        fall;
        logic        nv_wr;
        logic [15:0] nv_wait;
        logic [15:0] nv_ramp;
    } st_t;

    st_t s_q;
    st_t s_d;
    logic [7:0] sum_now;
    logic       ms_tick;

    bucket_if wait_b ();
    bucket_if ramp_b ();

    assign wait_b.mant = s_q.wait_m;
    assign ramp_b.mant = s_q.ramp_m;

    toff_bucket #(.ZERO_IS_ONE(1'b0)) u_wait_map (.b(wait_b));
    toff_bucket #(.ZERO_IS_ONE(1'b1)) u_ramp_map (.b(ramp_b));

    assign ms_tick = (s_q.div == 32'(CYC_MS - 1));

    // Summary gathered from lower-level sources, no write path
    always_comb
    begin
        sum_now               = 8'h00;                        // [R11]
        sum_now[SUM_OFF_BIT]  = ~CONV_EN_IN;                  // [R12]
        sum_now[SUM_OVF_BIT]  = VOUT_STATUS_IN[SRC_FAULT_BIT];  // [R13] [R15]
        sum_now[SUM_OCF_BIT]  = IOUT_STATUS_IN[SRC_FAULT_BIT];  // [R14] [R15]
        sum_now[SUM_TEMP_BIT] = |TEMP_STATUS_IN;              // [R16]
        sum_now[SUM_CML_BIT]  = |CML_STATUS_IN;               // [R17]
        sum_now[SUM_OTH_BIT]  = (|VOUT_STATUS_IN[6:2])
                              | (|IOUT_STATUS_IN[6:0])
                              | (|INPUT_STATUS_IN);           // [R18] [R19]
    end

    always_comb
    begin
        s_d       = s_q;
        s_d.ack   = 1'b0;
        s_d.nack  = 1'b0;
        s_d.fall  = 1'b0;
        s_d.nv_wr = 1'b0;
        s_d.sum   = sum_now;                                  // [R20]
        s_d.div   = ms_tick ? 32'h0000_0000 : s_q.div + 32'h1;

        // Command port
        if (CMD_VALID_IN)
        begin
            unique case (CMD_CODE_IN)
                CMD_TOFF_WAIT:
                begin
                    s_d.ack = 1'b1;
                    if (CMD_WRITE_IN)
                        s_d.wait_m = CMD_WDATA_IN[6:0];       // [R02]
                    s_d.rdata = {EXP_FIXED, 4'h0, s_q.wait_m}; // [R01] [R02]
                end
                CMD_TOFF_RAMP:
                begin
                    s_d.ack = 1'b1;
                    if (CMD_WRITE_IN)
                        s_d.ramp_m = CMD_WDATA_IN[6:0];       // [R02]
                    s_d.rdata = {EXP_FIXED, 4'h0, s_q.ramp_m}; // [R01] [R02]
                end
                CMD_SUMMARY:
                begin
                    s_d.ack   = ~CMD_WRITE_IN;                // [R11] [R20]
                    s_d.nack  = CMD_WRITE_IN;
                    s_d.rdata = {8'h00, s_q.sum};
                end
                default:
                begin
                    s_d.nack  = 1'b1;
                    s_d.rdata = 16'h0000;
                end
            endcase
        end

        // Store-all snapshot of both settings
        if (STORE_ALL_IN)
        begin
            s_d.nv_wr   = 1'b1;                               // [R10]
            s_d.nv_wait = {EXP_FIXED, 4'h0, s_q.wait_m};
            s_d.nv_ramp = {EXP_FIXED, 4'h0, s_q.ramp_m};
        end

        // Turn-off sequencer in 1 ms steps
        unique case (s_q.state)
            ST_RUN:
            begin
                if (STOP_REQ_IN)
                begin
                    s_d.div = 32'h0000_0000;
                    if (wait_b.ms == 7'h00)
                    begin
                        s_d.state = ST_RAMP;                  // [R06]
                        s_d.cnt   = ramp_b.ms;
                        s_d.fall  = 1'b1;
                    end
                    else
                    begin
                        s_d.state = ST_WAIT;                  // [R06]
                        s_d.cnt   = wait_b.ms;
                    end
                end
            end
            ST_WAIT:
            begin
                if (ms_tick)
                begin
                    if (s_q.cnt == 7'h01)
                    begin
                        s_d.state = ST_RAMP;                  // [R06] [R07]
                        s_d.cnt   = ramp_b.ms;                // [R08]
                        s_d.fall  = 1'b1;
                    end
                    else
                        s_d.cnt = s_q.cnt - 7'h01;
                end
            end
            ST_RAMP:
            begin
                if (ms_tick)
                begin
                    if (s_q.cnt == 7'h01)
                        s_d.state = ST_OFF;                   // [R07]
                    s_d.cnt = s_q.cnt - 7'h01;
                end
            end
            ST_OFF:
            begin
                if (START_REQ_IN)
                    s_d.state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            s_q         <= '0;
            s_q.state   <= ST_OFF;
            s_q.wait_m  <= MANT_RESET;                        // [R02]
            s_q.ramp_m  <= MANT_RESET;
            s_q.sum     <= SUMMARY_RESET;                     // [R19]
        end
        else
            s_q <= s_d;
    end

    assign CMD_RDATA_OUT  = s_q.rdata;
    assign CMD_ACK_OUT    = s_q.ack;
    assign CMD_NACK_OUT   = s_q.nack;
    assign NV_WR_OUT      = s_q.nv_wr;
    assign NV_WAIT_OUT    = s_q.nv_wait;
    assign NV_RAMP_OUT    = s_q.nv_ramp;
    assign FALL_START_OUT = s_q.fall;
    assign RAMPING_OUT    = (s_q.state == ST_RAMP);
    assign OUTPUT_OFF_OUT = (s_q.state == ST_OFF);
    assign SUMMARY_OUT    = s_q.sum;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);

    sequence s_stop_now;
        STOP_REQ_IN && s_q.state == ST_RUN && wait_b.ms == 7'h00;
    endsequence

    sequence s_wait_last;
        s_q.state == ST_WAIT && ms_tick && s_q.cnt == 7'h01;
    endsequence

    sequence s_stop_wait;
        STOP_REQ_IN && s_q.state == ST_RUN && wait_b.ms != 7'h00;
    endsequence

    sequence s_ramp_last;
        s_q.state == ST_RAMP && ms_tick && s_q.cnt == 7'h01;
    endsequence

    a_sum_ovf_follow: assert property (                      // [R13]
        VOUT_STATUS_IN[SRC_FAULT_BIT] |=> SUMMARY_OUT[SUM_OVF_BIT])
        else $error("summary overvoltage bit not mirrored");

    a_sum_ocf_follow: assert property (                      // [R14]
        IOUT_STATUS_IN[7] |=> SUMMARY_OUT[SUM_OCF_BIT])
        else $error("summary overcurrent bit not mirrored");

    a_sum_unused_zero: assert property (                     // [R11]
        SUMMARY_OUT[7] == 1'b0 && SUMMARY_OUT[3] == 1'b0)
        else $error("unused summary bits set");

    a_sum_off_bit: assert property (                         // [R12]
        !CONV_EN_IN |=> SUMMARY_OUT[SUM_OFF_BIT])
        else $error("off bit clear while converter disabled");

    a_sum_temp_cml: assert property (                        // [R16] [R17]
        (|TEMP_STATUS_IN) && !(|CML_STATUS_IN)
        |=> SUMMARY_OUT[SUM_TEMP_BIT] && !SUMMARY_OUT[SUM_CML_BIT])
        else $error("temperature or cml summary bit wrong");

    a_sum_write_keep: assert property (                      // [R20]
        CMD_VALID_IN && CMD_WRITE_IN && CMD_CODE_IN == CMD_SUMMARY
        |=> CMD_NACK_OUT && !CMD_ACK_OUT)
        else $error("summary write accepted");

    a_mant_upper_zero: assert property (                     // [R02]
        CMD_ACK_OUT |-> CMD_RDATA_OUT[15:7] == 9'h000)
        else $error("exponent or upper mantissa bits nonzero");

    a_wait_bucket_mid: assert property (                     // [R04] [R05]
        (wait_b.mant == 7'h08 |-> wait_b.ms == 7'h07) and
        (wait_b.mant == 7'h3F |-> wait_b.ms == 7'h48))
        else $error("wait bucket mapping wrong");

    a_ramp_min_one: assert property (                        // [R08] [R09]
        ramp_b.ms != 7'h00)
        else $error("ramp time of zero ms");

    a_stop_fall_now: assert property (                       // [R06]
        s_stop_now |=> FALL_START_OUT && RAMPING_OUT)
        else $error("fall not started on zero wait");

    a_wait_to_ramp: assert property (                        // [R07]
        s_wait_last |=> FALL_START_OUT ##1 RAMPING_OUT && !FALL_START_OUT)
        else $error("ramp not entered after wait");

    a_sum_ovf_clear: assert property (                       // [R13] [R20]
        !VOUT_STATUS_IN[SRC_FAULT_BIT] |=> !SUMMARY_OUT[SUM_OVF_BIT])
        else $error("summary overvoltage bit not cleared");

    a_sum_ocf_clear: assert property (                       // [R14] [R20]
        !IOUT_STATUS_IN[SRC_FAULT_BIT] |=> !SUMMARY_OUT[SUM_OCF_BIT])
        else $error("summary overcurrent bit not cleared");

    a_sum_on_bit: assert property (                          // [R12]
        CONV_EN_IN |=> !SUMMARY_OUT[SUM_OFF_BIT])
        else $error("off bit set while converter enabled");

    a_sum_oth_set: assert property (                         // [R18] [R19]
        (|VOUT_STATUS_IN[6:2]) || (|IOUT_STATUS_IN[6:0])
        || (|INPUT_STATUS_IN) |=> SUMMARY_OUT[SUM_OTH_BIT])
        else $error("other summary bit not set");

    a_sum_oth_clear: assert property (                       // [R18] [R20]
        (VOUT_STATUS_IN[6:2] == 5'h00) && (IOUT_STATUS_IN[6:0] == 7'h00)
        && (INPUT_STATUS_IN == 8'h00)
        |=> !SUMMARY_OUT[SUM_OTH_BIT])
        else $error("other summary bit not cleared");

    a_sum_cml_set: assert property (                         // [R17]
        (|CML_STATUS_IN) |=> SUMMARY_OUT[SUM_CML_BIT])
        else $error("cml summary bit not set");

    a_sum_temp_clear: assert property (                      // [R16] [R20]
        TEMP_STATUS_IN == 8'h00 |=> !SUMMARY_OUT[SUM_TEMP_BIT])
        else $error("temperature summary bit not cleared");

    a_exp_fixed: assert property (                           // [R01]
        CMD_ACK_OUT |-> CMD_RDATA_OUT[15:11] == EXP_FIXED)
        else $error("exponent field not fixed");

    a_wait_write_low: assert property (                      // [R02]
        CMD_VALID_IN && CMD_WRITE_IN && CMD_CODE_IN == CMD_TOFF_WAIT
        |=> s_q.wait_m == $past(CMD_WDATA_IN[6:0]))
        else $error("wait mantissa not taken from low bits");

    a_ramp_write_low: assert property (                      // [R02]
        CMD_VALID_IN && CMD_WRITE_IN && CMD_CODE_IN == CMD_TOFF_RAMP
        |=> s_q.ramp_m == $past(CMD_WDATA_IN[6:0]))
        else $error("ramp mantissa not taken from low bits");

    a_cmd_ack_known: assert property (                       // [R02]
        CMD_VALID_IN && (CMD_CODE_IN == CMD_TOFF_WAIT ||
        CMD_CODE_IN == CMD_TOFF_RAMP) |=> CMD_ACK_OUT && !CMD_NACK_OUT)
        else $error("setting command not acknowledged");

    a_summary_read_ack: assert property (                    // [R11]
        CMD_VALID_IN && !CMD_WRITE_IN && CMD_CODE_IN == CMD_SUMMARY
        |=> CMD_ACK_OUT && CMD_RDATA_OUT[15:8] == 8'h00)
        else $error("summary read not one byte");

    a_store_snapshot: assert property (                      // [R10]
        STORE_ALL_IN |=> NV_WR_OUT && NV_WAIT_OUT[15:7] == 9'h000
        && NV_RAMP_OUT[15:7] == 9'h000)
        else $error("store snapshot wrong");

    a_stop_wait_enter: assert property (                     // [R06]
        s_stop_wait |=> !FALL_START_OUT && !RAMPING_OUT && !OUTPUT_OFF_OUT)
        else $error("fall started before wait elapsed");

    a_ramp_to_off: assert property (                         // [R07]
        s_ramp_last |=> OUTPUT_OFF_OUT && !RAMPING_OUT)
        else $error("output not off after ramp");

    a_off_holds: assert property (                           // [R07]
        OUTPUT_OFF_OUT && !START_REQ_IN |=> OUTPUT_OFF_OUT)
        else $error("off state left without start");

    a_wait_zero_ms: assert property (                        // [R04]
        wait_b.mant == 7'h00 |-> wait_b.ms == 7'h00)
        else $error("zero wait mantissa not zero ms");

    a_wait_top_ms: assert property (                         // [R05]
        wait_b.mant > 7'h56 |-> wait_b.ms == 7'h64)
        else $error("top wait bucket wrong");

    a_ramp_zero_one: assert property (                       // [R08] [R09]
        ramp_b.mant <= 7'h01 |-> ramp_b.ms == 7'h01)
        else $error("ramp zero or one not 1 ms");
endmodule
